// File: rtl/epi_pkg.sv
package epi_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] EPI_OFF_MASK0 = 8'h09;
  localparam logic [7:0] EPI_OFF_MASK1 = 8'h0A;
  localparam logic [7:0] EPI_OFF_FLAG = 8'h0B;
  localparam logic [7:0] EPI_OFF_GMASK = 8'h0C;
  localparam logic [7:0] EPI_OFF_MASK2 = 8'h1A;
  localparam logic [7:0] EPI_OFF_MCU_CONTROL_REG = 8'h35;
  localparam logic [7:0] EPI_RST_VAL = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int EPI_BIT_EXT = 0;
  localparam int EPI_BIT_G0 = 4;
  localparam int EPI_BIT_G1 = 5;
  localparam int EPI_BIT_G2 = 6;
  localparam int EPI_BIT_SC0 = 6;
  localparam int EPI_BIT_SC1 = 7;
  localparam logic [7:0] EPI_FLAG_USED = 8'h71;
  localparam logic [7:0] EPI_GMASK_USED = 8'h71;
  localparam logic [7:0] EPI_MASK1_USED = 8'h0F;
  localparam logic [7:0] EPI_MASK2_USED = 8'h3F;
  localparam logic [7:0] EPI_MCU_CONTROL_REG_USED = 8'hC0;
  localparam int EPI_NPINS = 18;
  localparam int EPI_G1_LO = 8;
  localparam int EPI_G2_LO = 12;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    EPI_SENSE_LOW,
    EPI_SENSE_ANY,
    EPI_SENSE_FALL,
    EPI_SENSE_RISE
  } epi_sense_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epi_bus_req_t;

  typedef struct packed {
    logic ext;
    logic g0;
    logic g1;
    logic g2;
  } epi_vec_t;
endpackage

// File: rtl/epi_flags.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// - ext irq needs its enable and global enable
// - sense bits pick level, change or edge
// - pin activity triggers even when driven
// - flag register at 0x0B, reserved zero
// - group 2 change sets flag bit 6
// - group 1 change sets flag bit 5
// - group 0 change sets flag bit 4
// - flag, enable and global request vector
// - acknowledge clears matching flag
// - writing one clears a flag
// - ext edge or change sets bit 0
// - ext flag stays zero in level mode
// - group 2 mask at 0x1A, bits 5:0
// - group 1 mask at 0x0A, bits 3:0
// - group 0 mask at 0x09, bits 7:0
// - pin needs mask and group enable
// - sense code 00 low,01 any,10 fall,11 rise
// - group enables at 0x0C bits 6:4
// - ext pin sampled before edge detect
// - low level keeps request while pin low
module epi_flags (
  input wire logic clk_sys,
  input wire logic rst,
  input wire epi_pkg::epi_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic ext_irq0,
  input wire logic [epi_pkg::EPI_NPINS-1:0] pin_in,
  input wire logic global_irq_enable,
  input wire epi_pkg::epi_vec_t irq_ack,
  output epi_pkg::epi_vec_t irq_req
);
  import epi_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] gmask;
    logic [7:0] mcu_control_reg;
    logic [7:0] flag;
    logic ext_s;
    logic ext_p;
    logic [EPI_NPINS-1:0] pin_s;
    logic [EPI_NPINS-1:0] pin_p;
    logic [7:0] rdata;
    epi_vec_t req;
  } epi_state_t;

  epi_state_t s_q;
  epi_state_t s_d;

  function automatic logic hit(input epi_bus_req_t b, input logic [7:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  logic [EPI_NPINS-1:0] chg;
  logic [EPI_NPINS-1:0] en;
  logic ext_evt;
  logic ext_low;
  epi_sense_t sense;

  always_comb begin
    s_d = s_q;
    // pins are plain inputs, so a driven pin still toggles these
    s_d.ext_s = ext_irq0;
    s_d.ext_p = s_q.ext_s;
    s_d.pin_s = pin_in;
    s_d.pin_p = s_q.pin_s;
    chg = s_q.pin_s ^ s_q.pin_p;
    en = {s_q.mask2[5:0], s_q.mask1[3:0], s_q.mask0};
    en[EPI_G1_LO-1:0] &= {EPI_G1_LO{s_q.gmask[EPI_BIT_G0]}};
    en[EPI_G2_LO-1:EPI_G1_LO] &= {(EPI_G2_LO-EPI_G1_LO){s_q.gmask[EPI_BIT_G1]}};
    en[EPI_NPINS-1:EPI_G2_LO] &= {(EPI_NPINS-EPI_G2_LO){s_q.gmask[EPI_BIT_G2]}};
    sense = epi_sense_t'(s_q.mcu_control_reg[EPI_BIT_SC1:EPI_BIT_SC0]);
    ext_low = 1'b0;
    ext_evt = 1'b0;
    unique case (sense)
      EPI_SENSE_LOW: ext_low = !s_q.ext_s;
      EPI_SENSE_ANY: ext_evt = s_q.ext_s ^ s_q.ext_p;
      EPI_SENSE_FALL: ext_evt = s_q.ext_p && !s_q.ext_s;
      EPI_SENSE_RISE: ext_evt = s_q.ext_s && !s_q.ext_p;
    endcase

    // ************************************************************
    // register writes
    // ************************************************************
    if (hit(bus_req, EPI_OFF_MASK0)) s_d.mask0 = bus_req.wdata;
    if (hit(bus_req, EPI_OFF_MASK1)) s_d.mask1 = bus_req.wdata & EPI_MASK1_USED;
    if (hit(bus_req, EPI_OFF_MASK2)) s_d.mask2 = bus_req.wdata & EPI_MASK2_USED;
    if (hit(bus_req, EPI_OFF_GMASK)) s_d.gmask = bus_req.wdata & EPI_GMASK_USED;
    if (hit(bus_req, EPI_OFF_MCU_CONTROL_REG)) s_d.mcu_control_reg = bus_req.wdata & EPI_MCU_CONTROL_REG_USED;
    // clear by one, zeros leave flags alone
    if (hit(bus_req, EPI_OFF_FLAG)) s_d.flag = s_q.flag & ~(bus_req.wdata & EPI_FLAG_USED);
    // acknowledge clears its own flag
    if (irq_ack.ext) s_d.flag[EPI_BIT_EXT] = 1'b0;
    if (irq_ack.g0) s_d.flag[EPI_BIT_G0] = 1'b0;
    if (irq_ack.g1) s_d.flag[EPI_BIT_G1] = 1'b0;
    if (irq_ack.g2) s_d.flag[EPI_BIT_G2] = 1'b0;
    // sets follow the write-one and ack clears so a same-cycle event wins over both
    if (ext_evt) s_d.flag[EPI_BIT_EXT] = 1'b1;
    if (|(chg[EPI_G1_LO-1:0] & en[EPI_G1_LO-1:0])) s_d.flag[EPI_BIT_G0] = 1'b1;
    if (|(chg[EPI_G2_LO-1:EPI_G1_LO] & en[EPI_G2_LO-1:EPI_G1_LO]))
      s_d.flag[EPI_BIT_G1] = 1'b1;
    if (|(chg[EPI_NPINS-1:EPI_G2_LO] & en[EPI_NPINS-1:EPI_G2_LO]))
      s_d.flag[EPI_BIT_G2] = 1'b1;
    // level mode never latches the flag
    if (epi_sense_t'(s_d.mcu_control_reg[EPI_BIT_SC1:EPI_BIT_SC0]) == EPI_SENSE_LOW)
      s_d.flag[EPI_BIT_EXT] = 1'b0;

    // ************************************************************
    // vector requests
    // ************************************************************
    // level request follows the pin, not the flag
    s_d.req.ext = global_irq_enable && s_d.gmask[EPI_BIT_EXT]
                  && (s_d.flag[EPI_BIT_EXT] || ext_low);
    s_d.req.g0 = global_irq_enable && s_d.gmask[EPI_BIT_G0] && s_d.flag[EPI_BIT_G0];
    s_d.req.g1 = global_irq_enable && s_d.gmask[EPI_BIT_G1] && s_d.flag[EPI_BIT_G1];
    s_d.req.g2 = global_irq_enable && s_d.gmask[EPI_BIT_G2] && s_d.flag[EPI_BIT_G2];

    // ************************************************************
    // reads
    // ************************************************************
    s_d.rdata = EPI_RST_VAL;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        EPI_OFF_MASK0: s_d.rdata = s_q.mask0;
        EPI_OFF_MASK1: s_d.rdata = s_q.mask1;
        EPI_OFF_MASK2: s_d.rdata = s_q.mask2;
        EPI_OFF_GMASK: s_d.rdata = s_q.gmask;
        EPI_OFF_MCU_CONTROL_REG: s_d.rdata = s_q.mcu_control_reg;
        EPI_OFF_FLAG: s_d.rdata = s_q.flag & EPI_FLAG_USED;
        default: s_d.rdata = EPI_RST_VAL;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign irq_req = s_q.req;
endmodule

// File: sim/epi_core_model.sv
`timescale 1ns/10ps
module epi_core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ack_on,
  input wire logic [3:0] lat,
  input wire epi_pkg::epi_vec_t irq_req,
  output epi_pkg::epi_vec_t irq_ack
);
  import epi_pkg::*;
  logic [3:0] wait_q;
  // ******
  // dispatch, lowest vector first
  // ******
  always_ff @(posedge clk_sys) begin
    irq_ack <= '0;
    // waits after each ack so a stale request is never taken twice
    if (rst || !ack_on || irq_req == '0 || irq_ack != '0) begin
      wait_q <= '0;
    end else if (wait_q < lat) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= '0;
      if (irq_req.ext) irq_ack.ext <= 1'b1;
      else if (irq_req.g0) irq_ack.g0 <= 1'b1;
      else if (irq_req.g1) irq_ack.g1 <= 1'b1;
      else irq_ack.g2 <= 1'b1;
    end
  end
endmodule

// File: sim/epi_flags_props.sv
`timescale 1ns/10ps
module epi_flags_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire epi_pkg::epi_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic [epi_pkg::EPI_NPINS-1:0] pin_in,
  input wire logic global_irq_enable,
  input wire epi_pkg::epi_vec_t irq_ack,
  input wire epi_pkg::epi_vec_t irq_req
);
  import epi_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ******
  // port relations
  // ******
  flag_rsvd_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == EPI_OFF_FLAG
    |-> rdata[7] == 1'b0 && rdata[3:1] == 3'h0) else $error("flag reserved set");
  mask1_rsvd_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == EPI_OFF_MASK1
    |-> rdata[7:4] == 4'h0) else $error("mask1 reserved set");
  mask2_rsvd_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == EPI_OFF_MASK2
    |-> rdata[7:6] == 2'h0) else $error("mask2 reserved set");
  glob_gate_a: assert property (!global_irq_enable && !$past(global_irq_enable)
    |-> irq_req == '0) else $error("request without global enable");
  ack_clear_a: assert property (irq_ack.g1 && $past(pin_in) == $past(pin_in, 2)
    |=> !irq_req.g1) else $error("ack left request");
  wr1_clear_a: assert property (bus_req.wr && bus_req.addr == EPI_OFF_FLAG && bus_req.wdata[4]
    && $past(pin_in) == $past(pin_in, 2) |=> !irq_req.g0) else $error("write one kept g0");
  g0_cause_a: assert property ($rose(irq_req.g0) |-> $past(bus_req.wr)
    || $past(pin_in[7:0], 2) != $past(pin_in[7:0], 3) || !$past(global_irq_enable, 2))
    else $error("g0 without cause");
  g1_cause_a: assert property ($rose(irq_req.g1) |-> $past(bus_req.wr)
    || $past(pin_in[11:8], 2) != $past(pin_in[11:8], 3) || !$past(global_irq_enable, 2))
    else $error("g1 without cause");
endmodule
bind epi_flags epi_flags_props u_props (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
  .rdata(rdata), .pin_in(pin_in), .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
  .irq_req(irq_req));

// File: sim/test_ext_pin_change_irq_flags.sv
`timescale 1ns/10ps
module test_ext_pin_change_irq_flags;
  import epi_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ext_irq0 = 1'b1;
  logic global_irq_enable = 1'b0;
  logic ack_on = 1'b0;
  logic [EPI_NPINS-1:0] pin_in = '0;
  logic [7:0] rdata;
  epi_bus_req_t bus_req = '0;
  epi_vec_t irq_ack;
  epi_vec_t irq_req;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] regs [6] = '{EPI_OFF_MASK0, EPI_OFF_MASK1, EPI_OFF_MASK2, EPI_OFF_GMASK,
    EPI_OFF_MCU_CONTROL_REG, 8'h20};
  logic [7:0] vals [6] = '{8'hFF, 8'h0F, 8'h3F, 8'h71, 8'hC0, 8'h00};
  always #20 clk_sys = ~clk_sys;
  epi_flags DUT (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .ext_irq0(ext_irq0), .pin_in(pin_in), .global_irq_enable(global_irq_enable),
    .irq_ack(irq_ack), .irq_req(irq_req));
  epi_core_model core (.clk_sys(clk_sys), .rst(rst), .ack_on(ack_on), .lat(4'h2),
    .irq_req(irq_req), .irq_ack(irq_ack));
  // ******
  // tasks
  // ******
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    chk(rdata, e);
  endtask
  // index EPI_NPINS stands for the dedicated pin
  task automatic tog(input int n);
    @(posedge clk_sys);
    if (n == EPI_NPINS) ext_irq0 <= ~ext_irq0;
    else pin_in[n] <= ~pin_in[n];
    repeat (3) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(EPI_OFF_FLAG, 8'h00);
    foreach (regs[i]) wr(regs[i], 8'hFF);
    foreach (regs[i]) rd(regs[i], vals[i]);
    wr(EPI_OFF_FLAG, 8'hFF);
    rd(EPI_OFF_FLAG, 8'h00);
    global_irq_enable <= 1'b1;
    tog(3);
    rd(EPI_OFF_FLAG, 8'h10);
    tog(9);
    rd(EPI_OFF_FLAG, 8'h30);
    tog(15);
    rd(EPI_OFF_FLAG, 8'h70);
    chk({4'h0, irq_req}, 8'h07);
    wr(EPI_OFF_FLAG, 8'h10);
    wr(EPI_OFF_FLAG, 8'h00);
    rd(EPI_OFF_FLAG, 8'h60);
    ack_on <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rd(EPI_OFF_FLAG, 8'h00);
    ack_on <= 1'b0;
    wr(EPI_OFF_MASK0, 8'hF7);
    tog(3);
    rd(EPI_OFF_FLAG, 8'h00);
    global_irq_enable <= 1'b0;
    tog(0);
    rd(EPI_OFF_FLAG, 8'h10);
    chk({4'h0, irq_req}, 8'h00);
    wr(EPI_OFF_FLAG, 8'h10);
    global_irq_enable <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      wr(EPI_OFF_MCU_CONTROL_REG, {s[1:0], 6'h00});
      wr(EPI_OFF_FLAG, 8'h01);
      tog(EPI_NPINS);
      rd(EPI_OFF_FLAG, {7'h00, s != 3});
      wr(EPI_OFF_FLAG, 8'h01);
      tog(EPI_NPINS);
      rd(EPI_OFF_FLAG, {7'h00, s != 2});
    end
    wr(EPI_OFF_MCU_CONTROL_REG, 8'h00);
    tog(EPI_NPINS);
    rd(EPI_OFF_FLAG, 8'h00);
    chk({4'h0, irq_req}, 8'h08);
    wr(EPI_OFF_GMASK, 8'h70);
    repeat (2) @(negedge clk_sys);
    chk({4'h0, irq_req}, 8'h00);
    close_out();
  end
endmodule
